// ---- hdl/bpm_pkg.sv ----
package bpm_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_FREQ_MHZ       = 100;
	localparam int DRV_EN_DELAY_NS    = 10000;
	localparam int IDLE_TIMEOUT_NS    = 100000;
	localparam int IDLE_TIMEOUT_MIN_NS = 70000;
	localparam int IDLE_TIMEOUT_MAX_NS = 130000;
	// Least time rounds up
	localparam int DRV_EN_CYC         = (DRV_EN_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int IDLE_TIMEOUT_CYC   = (IDLE_TIMEOUT_NS * CLK_FREQ_MHZ) / 1000;
	localparam int CNT_W              = 16;

	// ****************************************
	// Modes
	// ****************************************
	typedef enum logic [3:0] {
		MODE_STARTUP = 4'b0001,
		MODE_SAVE    = 4'b0010,
		MODE_OPER    = 4'b0100,
		MODE_SHUT    = 4'b1000
	} bpm_mode_e;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  CTRL_OFS       = 8'h00;
	localparam logic [7:0]  STATUS_OFS     = 8'h04;
	localparam int          CTRL_INHIBIT_BIT = 0;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
	localparam int          ST_MODE_LSB    = 0;
	localparam int          ST_FAULT_BIT   = 4;
	localparam int          ST_SWITCH_BIT  = 5;
	localparam int          ST_HVGEN_BIT   = 6;
	localparam int          ST_REFEN_BIT   = 7;
	localparam int          ST_REFHI_BIT   = 8;

endpackage : bpm_pkg

// ---- hdl/bpm_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Two-stage synchroniser
// ****************************************
module bpm_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : bpm_sync
`default_nettype wire

// ---- hdl/bpm_sequencer.sv ----
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module bpm_sequencer #(
	parameter int IDLE_TIMEOUT = bpm_pkg::IDLE_TIMEOUT_CYC
) (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Comparator results
	input  wire logic        supply_at_turn_on,
	input  wire logic        supply_below_save_low,
	input  wire logic        supply_below_ref_off,
	input  wire logic        supply_below_turn_off,
	input  wire logic        ref_above_enable,
	input  wire logic        ref_below_uv,
	input  wire logic        supply_above_reg_start,
	input  wire logic        supply_above_reg_on,
	input  wire logic        supply_below_reg_off,
	input  wire logic        current_sense_trip,
	// Gate commands
	input  wire logic        high_side_cmd_in,
	input  wire logic        low_side_cmd_pin,
	input  wire logic        power_factor_cmd_in,
	input  wire logic        heater_cmd_in,
	// Power controls
	output logic             hv_startup_generator_on,
	output logic             ref_enable,
	output logic             ref_high_current,
	output logic             ref_sink_clamp,
	output logic             two_point_regulator_en,
	output logic             regulator_supply_switch,
	output logic             overcurrent_protection_en,
	output logic             drivers_enable,
	output var bpm_pkg::bpm_mode_e mode,
	// Gate outputs
	output logic             high_side_gate_out,
	output logic             low_side_gate_out,
	output logic             power_factor_gate_out,
	output logic             heater_gate_out,
	output logic             bootstrap_switch_on,
	output logic             fault_flag_out
);
	import bpm_pkg::*;

	// ****************************************
	// Synchronisers
	// ****************************************
	logic [13:0] raw_in;
	logic [13:0] sync_in;
	logic        s_on, s_save_low, s_ref_off, s_turn_off, s_ref_good, s_ref_uv;
	logic        s_reg_start, s_reg_on, s_reg_off, s_trip;
	logic        s_hs, s_ls, s_pf, s_heat;
	logic        hs_d1_q, ls_d1_q;

	assign raw_in = {heater_cmd_in, power_factor_cmd_in, low_side_cmd_pin,
		high_side_cmd_in, current_sense_trip, supply_below_reg_off,
		supply_above_reg_on, supply_above_reg_start, ref_below_uv,
		ref_above_enable, supply_below_turn_off, supply_below_ref_off,
		supply_below_save_low, supply_at_turn_on};

	bpm_sync #(.W(14)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (raw_in),
		.sync_out (sync_in)
	);

	assign {s_heat, s_pf, s_ls, s_hs, s_trip, s_reg_off, s_reg_on, s_reg_start,
		s_ref_uv, s_ref_good, s_turn_off, s_ref_off, s_save_low, s_on} = sync_in;

	wire hs_fall = hs_d1_q & ~s_hs;
	wire ls_fall = ls_d1_q & ~s_ls;
	wire ls_edge = ls_d1_q ^ s_ls;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_d1_q <= 1'b0;
			ls_d1_q <= 1'b0;
		end else begin
			hs_d1_q <= s_hs;
			ls_d1_q <= s_ls;
		end
	end

	// ****************************************
	// Timers
	// ****************************************
	localparam logic [CNT_W-1:0] DRV_EN_LIM = CNT_W'(DRV_EN_CYC);
	localparam logic [CNT_W-1:0] IDLE_LIM   = CNT_W'(IDLE_TIMEOUT);

	bpm_mode_e        mode_q, mode_d;
	logic [CNT_W-1:0] save_cnt_q, save_cnt_d;
	logic [CNT_W-1:0] idle_cnt_q, idle_cnt_d;

	// Saturating increment, used by both timers
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
		input logic [CNT_W-1:0] lim);
		sat_inc = (v >= lim) ? v : v + CNT_W'(1);
	endfunction : sat_inc

	assign save_cnt_d = (mode_q != MODE_SAVE) ? '0 : sat_inc(save_cnt_q, DRV_EN_LIM);
	// idle time of low-side command; limit+1 means longer than timeout
	assign idle_cnt_d = (mode_q != MODE_OPER || ls_edge) ? '0 :
		sat_inc(idle_cnt_q, IDLE_LIM + CNT_W'(1));

	wire save_done = save_cnt_q >= DRV_EN_LIM;
	wire idle_out  = idle_cnt_q > IDLE_LIM;

	// ****************************************
	// Mode sequencer
	// ****************************************
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			MODE_STARTUP: begin
				if (s_on) begin
					mode_d = MODE_SAVE;
				end
			end
			MODE_SAVE: begin
				if (s_ref_off) begin
					mode_d = MODE_STARTUP;
				end else if (hs_fall && save_done && s_ref_good) begin
					mode_d = MODE_OPER;
				end
			end
			MODE_OPER: begin
				if (s_turn_off || s_ref_uv) begin
					mode_d = MODE_SHUT;
				end else if (idle_out) begin
					mode_d = MODE_SAVE;
				end
			end
			MODE_SHUT: begin
				if (s_ref_off) begin
					mode_d = MODE_STARTUP;
				end else if (s_on) begin
					mode_d = MODE_SAVE;
				end
			end
			default: mode_d = MODE_STARTUP;
		endcase
	end

	// ****************************************
	// Power controls
	// ****************************************
	logic cyc_gen_q, cyc_gen_d;
	logic sw_q, sw_d;
	logic fault_q, fault_d;
	logic inhibit_q;

	// hysteresis of the generator in save
	assign cyc_gen_d = (mode_q != MODE_SAVE) ? 1'b0 :
		s_save_low ? 1'b1 : s_on ? 1'b0 : cyc_gen_q;

	wire in_oper = mode_d == MODE_OPER;
	// generator on in start-up and shutdown, off in operating
	wire gen_d = (mode_d == MODE_STARTUP) || (mode_d == MODE_SHUT) ||
		(mode_d == MODE_SAVE && cyc_gen_d);
	// reference tracks supply, clamp is its inverse
	wire ref_en_d = (mode_d != MODE_STARTUP) && !s_ref_off;
	wire ref_hi_d = in_oper && ref_en_d;

	always_comb begin
		sw_d = sw_q;
		if (!in_oper) begin
			sw_d = 1'b0;
		end else if (s_reg_start) begin
			sw_d = 1'b1;
		end else if (ls_fall && s_reg_on) begin
			sw_d = 1'b1;
		end else if (ls_fall && s_reg_off) begin
			sw_d = 1'b0;
		end
	end

	// fault latch, set wins over release
	wire fault_set = (mode_q == MODE_OPER) && s_trip;
	wire fault_rel = !s_hs && !s_ls && !s_trip;
	assign fault_d = fault_set ? 1'b1 : fault_rel ? 1'b0 : fault_q;

	// ****************************************
	// Gate paths
	// ****************************************
	// Software inhibit blocks drivers without leaving operating mode
	wire drv_en_d = in_oper && !inhibit_q;
	wire overlap  = s_hs && s_ls;
	wire ls_gate_d = drv_en_d && s_ls && !overlap && !fault_d;
	wire hs_gate_d = drv_en_d && s_hs && !overlap && !fault_d;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q                    <= MODE_STARTUP;
			save_cnt_q                <= '0;
			idle_cnt_q                <= '0;
			cyc_gen_q                 <= 1'b0;
			sw_q                      <= 1'b0;
			fault_q                   <= 1'b0;
			mode                      <= MODE_STARTUP;
			hv_startup_generator_on   <= 1'b1;
			ref_enable                <= 1'b0;
			ref_high_current          <= 1'b0;
			ref_sink_clamp            <= 1'b1;
			two_point_regulator_en    <= 1'b0;
			regulator_supply_switch   <= 1'b0;
			overcurrent_protection_en <= 1'b0;
			drivers_enable            <= 1'b0;
			high_side_gate_out        <= 1'b0;
			low_side_gate_out         <= 1'b0;
			power_factor_gate_out     <= 1'b0;
			heater_gate_out           <= 1'b0;
			bootstrap_switch_on       <= 1'b0;
			fault_flag_out            <= 1'b0;
		end else begin
			mode_q                    <= mode_d;
			save_cnt_q                <= save_cnt_d;
			idle_cnt_q                <= idle_cnt_d;
			cyc_gen_q                 <= cyc_gen_d;
			sw_q                      <= sw_d;
			fault_q                   <= fault_d;
			mode                      <= mode_d;
			hv_startup_generator_on   <= gen_d;
			ref_enable                <= ref_en_d;
			ref_high_current          <= ref_hi_d;
			ref_sink_clamp            <= !ref_en_d;
			two_point_regulator_en    <= in_oper;
			regulator_supply_switch   <= sw_d;
			overcurrent_protection_en <= in_oper;
			drivers_enable            <= drv_en_d;
			high_side_gate_out        <= hs_gate_d;
			low_side_gate_out         <= ls_gate_d;
			power_factor_gate_out     <= drv_en_d && s_pf;
			heater_gate_out           <= drv_en_d && s_heat;
			// bootstrap in step with low-side gate
			bootstrap_switch_on       <= ls_gate_d;
			fault_flag_out            <= fault_d;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	// No wait state: every bus output is registered from the setup phase
	wire setup_ph   = psel && !penable;
	wire access_ok  = psel && penable && pready;
	wire hit_ctrl   = paddr == CTRL_OFS;
	wire hit_status = paddr == STATUS_OFS;
	wire mapped     = hit_ctrl || hit_status;
	wire wr_ctrl    = access_ok && pwrite && hit_ctrl && !pslverr;

	logic [31:0] status_w;
	logic [31:0] rd_mux;

	always_comb begin
		status_w = '0;
		status_w[ST_MODE_LSB +: 4] = mode_q;
		status_w[ST_FAULT_BIT]     = fault_q;
		status_w[ST_SWITCH_BIT]    = sw_q;
		status_w[ST_HVGEN_BIT]     = hv_startup_generator_on;
		status_w[ST_REFEN_BIT]     = ref_enable;
		status_w[ST_REFHI_BIT]     = ref_high_current;
	end

	assign rd_mux = hit_ctrl ? {31'h0000_0000, inhibit_q} : hit_status ? status_w : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			prdata    <= '0;
			inhibit_q <= CTRL_RST[CTRL_INHIBIT_BIT];
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph && (!mapped || (pwrite && hit_status));
			prdata  <= (setup_ph && !pwrite) ? rd_mux : '0;
			if (wr_ctrl) begin
				inhibit_q <= pwdata[CTRL_INHIBIT_BIT];
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_startup_outputs: assert property (
		mode == MODE_STARTUP |-> hv_startup_generator_on && ref_sink_clamp && !drivers_enable
			&& !two_point_regulator_en && !overcurrent_protection_en)
		else $error("start-up outputs wrong");
	chk_startup_exit: assert property (
		mode_q == MODE_STARTUP && s_on |=> mode_q == MODE_SAVE && !hv_startup_generator_on)
		else $error("start-up did not leave at turn-on");
	chk_save_fallback: assert property (
		mode_q == MODE_SAVE && s_ref_off |=> mode_q == MODE_STARTUP)
		else $error("save did not fall back");
	chk_oper_entry: assert property (
		mode_q == MODE_SAVE && mode_d == MODE_OPER |-> $fell(s_hs)
			&& save_cnt_q >= DRV_EN_LIM && s_ref_good)
		else $error("operating entered without conditions");
	chk_oper_outputs: assert property (
		mode == MODE_OPER |-> !hv_startup_generator_on && two_point_regulator_en
			&& overcurrent_protection_en)
		else $error("operating outputs wrong");
	chk_idle_timeout: assert property (
		mode_q == MODE_OPER && !s_turn_off && !s_ref_uv && idle_cnt_q > IDLE_LIM
		|=> mode_q == MODE_SAVE)
		else $error("idle timeout not honoured");
	chk_no_early_save: assert property (
		mode_q == MODE_OPER && mode_d == MODE_SAVE |-> idle_cnt_q > IDLE_LIM)
		else $error("left operating early");
	chk_uv_shutdown: assert property (
		mode_q == MODE_OPER && (s_turn_off || s_ref_uv) |=> mode == MODE_SHUT)
		else $error("undervoltage missed");
	chk_switch_start: assert property (
		mode_q == MODE_OPER && mode_d == MODE_OPER && s_reg_start |=> regulator_supply_switch)
		else $error("switch not closed at start level");
	chk_gates_off: assert property (
		!drivers_enable |-> !high_side_gate_out && !low_side_gate_out
			&& !power_factor_gate_out && !heater_gate_out)
		else $error("gate driven while disabled");
	chk_fault_gates: assert property (
		fault_flag_out |-> !high_side_gate_out && !low_side_gate_out)
		else $error("gate high during fault");
	chk_interlock: assert property (
		s_hs && s_ls |=> !high_side_gate_out && !low_side_gate_out)
		else $error("cross conduction");
	chk_bootstrap: assert property (
		bootstrap_switch_on == low_side_gate_out)
		else $error("bootstrap out of step");

	cov_enter_oper: cover property (mode_q == MODE_SAVE ##1 mode_q == MODE_OPER);
	cov_timeout: cover property (mode_q == MODE_OPER ##1 mode_q == MODE_SAVE);
	cov_shutdown: cover property (mode_q == MODE_SHUT ##1 mode_q == MODE_SAVE);
	cov_fault: cover property ($rose(fault_flag_out));
endmodule : bpm_sequencer
`default_nettype wire

// ---- tb/bpm_mcu_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Controller driving the gate commands
// ****************************************
module bpm_mcu_model (
	// Clock and test control
	input  wire logic pclk,
	input  wire logic allow_overlap,
	// Gate commands
	output logic      high_side_cmd_in,
	output logic      low_side_cmd_pin,
	output logic      power_factor_cmd_in,
	output logic      heater_cmd_in
);
	initial begin
		{high_side_cmd_in, low_side_cmd_pin, power_factor_cmd_in, heater_cmd_in} = 4'h0;
	end

	// Clean levels, no overlap
	// Overlap only when a test asks for it on purpose
	task automatic set_cmd(input logic hs, input logic ls, input logic pf, input logic he);
		@(posedge pclk);
		high_side_cmd_in    <= hs;
		low_side_cmd_pin    <= ls & (allow_overlap | ~hs);
		power_factor_cmd_in <= pf;
		heater_cmd_in       <= he;
	endtask : set_cmd
endmodule : bpm_mcu_model
`default_nettype wire

// ---- tb/ballast_power_mode_sequencer_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module ballast_power_mode_sequencer_test;
	import bpm_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	// Short idle limit keeps the run brief
	localparam int IDLE_T = 50;
	localparam logic [6:0] PW_START = 7'b1001000;
	localparam logic [6:0] PW_SAVE  = 7'b0100000;
	localparam logic [6:0] PW_OPER  = 7'b0110111;
	localparam logic [6:0] PW_SHUT  = 7'b1100000;
	typedef struct packed {logic [3:0] cmd; logic [4:0] gates;} bpm_row_s;
	localparam bpm_row_s ROWS [5] = '{'{4'h4, 5'h09}, '{4'ha, 5'h14}, '{4'h5, 5'h0b},
		'{4'hf, 5'h06}, '{4'h0, 5'h00}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, allow_overlap;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic supply_at_turn_on, supply_below_save_low, supply_below_ref_off, supply_below_turn_off;
	logic ref_above_enable, ref_below_uv, supply_above_reg_start, supply_above_reg_on;
	logic supply_below_reg_off, current_sense_trip;
	logic high_side_cmd_in, low_side_cmd_pin, power_factor_cmd_in, heater_cmd_in;
	logic hv_startup_generator_on, ref_enable, ref_high_current, ref_sink_clamp;
	logic two_point_regulator_en, regulator_supply_switch, overcurrent_protection_en;
	logic drivers_enable, high_side_gate_out, low_side_gate_out, power_factor_gate_out;
	logic heater_gate_out, bootstrap_switch_on, fault_flag_out;
	bpm_mode_e mode;
	int errors, checks;
	wire logic [4:0] gates = {high_side_gate_out, low_side_gate_out, power_factor_gate_out,
		heater_gate_out, bootstrap_switch_on};
	wire logic [10:0] st = {mode, hv_startup_generator_on, ref_enable, ref_high_current,
		ref_sink_clamp, two_point_regulator_en, overcurrent_protection_en, drivers_enable};

	bpm_sequencer #(.IDLE_TIMEOUT(IDLE_T)) uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.supply_at_turn_on, .supply_below_save_low, .supply_below_ref_off, .supply_below_turn_off,
		.ref_above_enable, .ref_below_uv, .supply_above_reg_start, .supply_above_reg_on,
		.supply_below_reg_off, .current_sense_trip, .high_side_cmd_in, .low_side_cmd_pin,
		.power_factor_cmd_in, .heater_cmd_in, .hv_startup_generator_on, .ref_enable,
		.ref_high_current, .ref_sink_clamp, .two_point_regulator_en, .regulator_supply_switch,
		.overcurrent_protection_en, .drivers_enable, .mode, .high_side_gate_out,
		.low_side_gate_out, .power_factor_gate_out, .heater_gate_out, .bootstrap_switch_on,
		.fault_flag_out
	);
	bpm_mcu_model mcu (
		.pclk, .allow_overlap, .high_side_cmd_in, .low_side_cmd_pin, .power_factor_cmd_in,
		.heater_cmd_in
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic step(input int n);
		repeat (n) @(posedge pclk);
	endtask : step

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic chk_st(input bpm_mode_e m, input logic [6:0] pw);
		chk("state", 32'(st), 32'({m, pw}));
	endtask : chk_st

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the watchdog ends a wait for the answer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		chk("pready", 32'(pready), 32'h1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic enter_oper;
		mcu.set_cmd(1'b1, 1'b0, 1'b0, 1'b0);
		step(1000);
		mcu.set_cmd(1'b0, 1'b0, 1'b0, 1'b0);
		step(6);
		chk_st(MODE_OPER, PW_OPER);
	endtask : enter_oper

	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (6000) @(posedge pclk);
		errors++;
		print_verdict();
	end

	initial begin
		errors = 0;
		checks = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, allow_overlap} = '0;
		{supply_at_turn_on, supply_below_save_low, supply_below_ref_off, supply_below_turn_off,
			ref_above_enable, ref_below_uv, supply_above_reg_start, supply_above_reg_on,
			supply_below_reg_off, current_sense_trip} = '0;
		step(12);
		presetn <= 1'b1;
		step(1);
		chk_st(MODE_STARTUP, PW_START);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl reset", rd, CTRL_RST);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		chk("unmapped data", rd, 32'h0);
		$display("test reset done");
		supply_at_turn_on <= 1'b1;
		ref_above_enable  <= 1'b1;
		step(6);
		chk_st(MODE_SAVE, PW_SAVE);
		supply_at_turn_on     <= 1'b0;
		supply_below_save_low <= 1'b1;
		step(6);
		chk("gen low", 32'(hv_startup_generator_on), 32'h1);
		supply_below_save_low <= 1'b0;
		step(6);
		// Hysteresis: stays on until turn-on level
		chk("gen hold", 32'(hv_startup_generator_on), 32'h1);
		supply_at_turn_on <= 1'b1;
		step(6);
		chk("gen off", 32'(hv_startup_generator_on), 32'h0);
		mcu.set_cmd(1'b1, 1'b0, 1'b0, 1'b0);
		step(6);
		chk_st(MODE_SAVE, PW_SAVE);
		mcu.set_cmd(1'b0, 1'b0, 1'b0, 1'b0);
		step(6);
		chk_st(MODE_SAVE, PW_SAVE);
		$display("test save done");
		enter_oper();
		allow_overlap <= 1'b1;
		foreach (ROWS[i]) begin
			mcu.set_cmd(ROWS[i].cmd[3], ROWS[i].cmd[2], ROWS[i].cmd[1], ROWS[i].cmd[0]);
			step(6);
			chk("gates", 32'(gates), 32'(ROWS[i].gates));
		end
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("status", rd & 32'h1df, 32'h184);
		apb(1'b1, STATUS_OFS, 32'hffff_ffff);
		chk("status write err", 32'(err), 32'h1);
		apb(1'b1, CTRL_OFS, 32'h1);
		mcu.set_cmd(1'b0, 1'b1, 1'b1, 1'b1);
		step(6);
		chk("inhibit", 32'({drivers_enable, gates}), 32'h0);
		apb(1'b1, CTRL_OFS, 32'h0);
		step(6);
		chk("gates back", 32'(gates), 32'h0f);
		$display("test gates done");
		supply_above_reg_start <= 1'b1;
		step(6);
		chk("switch start", 32'(regulator_supply_switch), 32'h1);
		supply_above_reg_start <= 1'b0;
		supply_below_reg_off   <= 1'b1;
		step(6);
		chk("switch held", 32'(regulator_supply_switch), 32'h1);
		mcu.set_cmd(1'b0, 1'b0, 1'b1, 1'b1);
		step(6);
		chk("switch open", 32'(regulator_supply_switch), 32'h0);
		supply_below_reg_off <= 1'b0;
		supply_above_reg_on  <= 1'b1;
		mcu.set_cmd(1'b0, 1'b1, 1'b0, 1'b0);
		step(6);
		chk("switch wait", 32'(regulator_supply_switch), 32'h0);
		mcu.set_cmd(1'b0, 1'b0, 1'b0, 1'b0);
		step(6);
		chk("switch close", 32'(regulator_supply_switch), 32'h1);
		$display("test switch done");
		mcu.set_cmd(1'b1, 1'b0, 1'b0, 1'b0);
		current_sense_trip <= 1'b1;
		step(6);
		chk("fault set", 32'({fault_flag_out, gates}), 32'h20);
		current_sense_trip <= 1'b0;
		step(6);
		chk("fault held", 32'({fault_flag_out, gates}), 32'h20);
		mcu.set_cmd(1'b0, 1'b0, 1'b0, 1'b0);
		step(6);
		chk("fault clear", 32'(fault_flag_out), 32'h0);
		$display("test fault done");
		mcu.set_cmd(1'b0, 1'b1, 1'b0, 1'b0);
		step(IDLE_T - 10);
		chk_st(MODE_OPER, PW_OPER);
		step(20);
		chk_st(MODE_SAVE, PW_SAVE);
		$display("test idle done");
		// Trip outside operating must not latch
		current_sense_trip <= 1'b1;
		step(6);
		chk("fault in save", 32'(fault_flag_out), 32'h0);
		current_sense_trip <= 1'b0;
		supply_at_turn_on  <= 1'b0;
		mcu.set_cmd(1'b0, 1'b0, 1'b0, 1'b0);
		enter_oper();
		ref_below_uv <= 1'b1;
		step(6);
		chk_st(MODE_SHUT, PW_SHUT);
		ref_below_uv      <= 1'b0;
		supply_at_turn_on <= 1'b1;
		step(6);
		chk_st(MODE_SAVE, PW_SAVE);
		supply_at_turn_on <= 1'b0;
		enter_oper();
		supply_below_turn_off <= 1'b1;
		step(6);
		chk_st(MODE_SHUT, PW_SHUT);
		supply_below_ref_off <= 1'b1;
		step(6);
		chk_st(MODE_STARTUP, PW_START);
		{supply_below_turn_off, supply_below_ref_off, supply_at_turn_on} <= 3'b001;
		step(6);
		chk_st(MODE_SAVE, PW_SAVE);
		supply_at_turn_on    <= 1'b0;
		supply_below_ref_off <= 1'b1;
		step(6);
		chk_st(MODE_STARTUP, PW_START);
		$display("test shutdown done");
		// Reset in mid-run from save, with inhibit set
		supply_below_ref_off <= 1'b0;
		supply_at_turn_on    <= 1'b1;
		step(6);
		apb(1'b1, CTRL_OFS, 32'h1);
		presetn <= 1'b0;
		step(2);
		presetn <= 1'b1;
		step(1);
		chk_st(MODE_STARTUP, PW_START);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl after reset", rd, CTRL_RST);
		step(6);
		chk_st(MODE_SAVE, PW_SAVE);
		$display("test mid reset done");
		print_verdict();
	end
endmodule : ballast_power_mode_sequencer_test
`default_nettype wire
